// ### hw/asc_avmm_slave.v
// avalon-mm slave front end: one-wait-state handshake and read data register
`timescale 1ns/10ps
module asc_avmm_slave #(
    parameter AW = 10
) (
    input  wire          mclk_i,
    input  wire          sys_rst_i,
    input  wire [AW-1:0] avs_address_i,
    input  wire          avs_read_i,
    input  wire          avs_write_i,
    input  wire [31:0]   avs_writedata_i,
    input  wire [3:0]    avs_byteenable_i,
    output wire          avs_waitrequest_o,
    output wire [31:0]   avs_readdata_o,
    output wire [1:0]    avs_response_o,
    output wire [7:0]    idx_o,
    output wire          wr_stb_o,
    output wire [1:0]    wr_byteen_o,
    input  wire [15:0]   rd_value_i,
    input  wire          rd_hit_i
);

    reg        ack_ff;
    reg [31:0] rdata_ff;
    reg [1:0]  resp_ff;
    wire       req;
    wire       aligned;

    // ------------------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------------------
    // wait one cycle so read data can be registered; ack drops right after
    // a write lands only at the accepting edge, never while waitrequest is high
    assign req     = avs_read_i | avs_write_i;
    assign aligned = (avs_address_i[1:0] == 2'b00);
    assign idx_o   = avs_address_i[9:2];
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr_stb_o    = avs_write_i & ack_ff & aligned & rd_hit_i;
    assign wr_byteen_o = avs_byteenable_i[1:0];
    assign avs_readdata_o = rdata_ff;
    assign avs_response_o = resp_ff;

    // ack and registered answer; unmapped addresses read zero with slave error
    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            resp_ff  <= 2'b00;
        end
        else
        begin
            ack_ff <= req & ~ack_ff;
            if (req & ~ack_ff)
            begin
                rdata_ff <= (avs_read_i & aligned & rd_hit_i) ?
                            {16'h0000, rd_value_i} : 32'h0000_0000;
                resp_ff  <= (aligned & rd_hit_i) ? 2'b00 : 2'b10;
            end
        end
    end

endmodule // asc_avmm_slave

// ### hw/asc_regs.vh
// register offsets, field positions and reset values for the step configuration bank
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

// ----------------------------------------------------------------------------
// register offsets (word index; byte address is four times the index)
// ----------------------------------------------------------------------------
`define ASC_STEP7_IDX        8'h97
`define ASC_STEP8_IDX        8'h98
`define ASC_ADDR_W           10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ASC_STEP7_RST        16'h0007
`define ASC_STEP8_RST        16'h0008

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ASC_EN_BIT           15
`define ASC_GAIN_HI          14
`define ASC_GAIN_LO          13
`define ASC_NEG_BIT          4
`define ASC_POS_HI           3
`define ASC_POS_LO           0
`define ASC_WR_MASK          16'hE01F

// ----------------------------------------------------------------------------
// positive input codes and gain decode
// ----------------------------------------------------------------------------
`define ASC_POS_LAST_EXT     4'h7
`define ASC_POS_TEMP         4'h8
`define ASC_POS_SHORT        4'h9
`define ASC_POS_TDAC         4'hA
`define ASC_GAIN_X1          3'h1
`define ASC_GAIN_X2          3'h2
`define ASC_GAIN_X4          3'h4

`endif

// ### hw/asc_step_cfg.v
// top of the sequencer step 7 / step 8 configuration bank
`timescale 1ns/10ps
module asc_step_cfg (
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    input  wire [9:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire        avs_waitrequest_o,
    output wire [31:0] avs_readdata_o,
    output wire [1:0]  avs_response_o,
    output wire        step7_enable_o,
    output wire [2:0]  step7_gain_o,
    output wire [7:0]  step7_pos_ext_o,
    output wire        step7_pos_temp_o,
    output wire        step7_pos_short_o,
    output wire        step7_pos_tdac_o,
    output wire        step7_pos_rail_o,
    output wire [3:0]  step7_rail_index_o,
    output wire        step7_neg_input_seven_o,
    output wire        step7_neg_auto_o,
    output wire        step8_enable_o,
    output wire [2:0]  step8_gain_o,
    output wire [7:0]  step8_pos_ext_o,
    output wire        step8_pos_temp_o,
    output wire        step8_pos_short_o,
    output wire        step8_pos_tdac_o,
    output wire        step8_pos_rail_o,
    output wire [3:0]  step8_rail_index_o,
    output wire        step8_neg_input_seven_o,
    output wire        step8_neg_auto_o
);
`include "asc_regs.vh"

    wire [7:0]  idx;
    wire        wr_stb;
    wire [1:0]  wr_byteen;
    wire [15:0] step7_value;
    wire [15:0] step8_value;
    wire        hit7;
    wire        hit8;
    reg  [15:0] rd_value;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    assign hit7 = (idx == `ASC_STEP7_IDX);
    assign hit8 = (idx == `ASC_STEP8_IDX);

    // read mux; no other word is mapped
    always @*
    begin
        rd_value = 16'h0000;
        if (hit7)
            rd_value = step7_value;
        else if (hit8)
            rd_value = step8_value;
    end

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    asc_avmm_slave #(
        .AW (`ASC_ADDR_W)
    ) u_bus (
        .mclk_i            (mclk_i),
        .sys_rst_i         (sys_rst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_waitrequest_o (avs_waitrequest_o),
        .avs_readdata_o    (avs_readdata_o),
        .avs_response_o    (avs_response_o),
        .idx_o             (idx),
        .wr_stb_o          (wr_stb),
        .wr_byteen_o       (wr_byteen),
        .rd_value_i        (rd_value),
        .rd_hit_i          (hit7 | hit8)
    );

    // ------------------------------------------------------------------------
    // step registers
    // ------------------------------------------------------------------------
    // step seven: disabled, gain one, positive input seven after reset
    asc_step_reg #(
        .RST_VAL (`ASC_STEP7_RST)
    ) u_step7 (
        .mclk_i            (mclk_i),
        .sys_rst_i         (sys_rst_i),
        .wr_en_i           (wr_stb & hit7),
        .wr_data_i         (avs_writedata_i[15:0]),
        .wr_byteen_i       (wr_byteen),
        .value_o           (step7_value),
        .enable_o          (step7_enable_o),
        .gain_o            (step7_gain_o),
        .pos_ext_onehot_o  (step7_pos_ext_o),
        .pos_temp_o        (step7_pos_temp_o),
        .pos_short_o       (step7_pos_short_o),
        .pos_tdac_o        (step7_pos_tdac_o),
        .pos_rail_o        (step7_pos_rail_o),
        .rail_index_o      (step7_rail_index_o),
        .neg_input_seven_o (step7_neg_input_seven_o),
        .neg_auto_o        (step7_neg_auto_o)
    );

    // step eight shares the layout; resets to the temperature sensor
    asc_step_reg #(
        .RST_VAL (`ASC_STEP8_RST)
    ) u_step8 (
        .mclk_i            (mclk_i),
        .sys_rst_i         (sys_rst_i),
        .wr_en_i           (wr_stb & hit8),
        .wr_data_i         (avs_writedata_i[15:0]),
        .wr_byteen_i       (wr_byteen),
        .value_o           (step8_value),
        .enable_o          (step8_enable_o),
        .gain_o            (step8_gain_o),
        .pos_ext_onehot_o  (step8_pos_ext_o),
        .pos_temp_o        (step8_pos_temp_o),
        .pos_short_o       (step8_pos_short_o),
        .pos_tdac_o        (step8_pos_tdac_o),
        .pos_rail_o        (step8_pos_rail_o),
        .rail_index_o      (step8_rail_index_o),
        .neg_input_seven_o (step8_neg_input_seven_o),
        .neg_auto_o        (step8_neg_auto_o)
    );

endmodule // asc_step_cfg

// ### hw/asc_step_reg.v
// one step configuration register with its field decode
`timescale 1ns/10ps
module asc_step_reg #(
    parameter [15:0] RST_VAL = 16'h0000
) (
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    input  wire        wr_en_i,
    input  wire [15:0] wr_data_i,
    input  wire [1:0]  wr_byteen_i,
    output wire [15:0] value_o,
    output wire        enable_o,
    output wire [2:0]  gain_o,
    output wire [7:0]  pos_ext_onehot_o,
    output wire        pos_temp_o,
    output wire        pos_short_o,
    output wire        pos_tdac_o,
    output wire        pos_rail_o,
    output wire [3:0]  rail_index_o,
    output wire        neg_input_seven_o,
    output wire        neg_auto_o
);
`include "asc_regs.vh"

    reg  [15:0] cfg_ff;
    wire [15:0] nxt_cfg;
    wire [15:0] lane_mask;
    wire [3:0]  pos_code;
    wire [1:0]  gain_code;

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    // byte lanes gate the write; reserved bits stay zero so they read as zero
    assign lane_mask = {{8{wr_byteen_i[1]}}, {8{wr_byteen_i[0]}}} & `ASC_WR_MASK;
    assign nxt_cfg   = (cfg_ff & ~lane_mask) | (wr_data_i & lane_mask);

    // reset value per instance
    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
            cfg_ff <= RST_VAL & `ASC_WR_MASK;
        else if (wr_en_i)
            cfg_ff <= nxt_cfg;
    end

    // ------------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------------
    assign value_o   = cfg_ff;
    assign pos_code  = cfg_ff[`ASC_POS_HI:`ASC_POS_LO];
    assign gain_code = cfg_ff[`ASC_GAIN_HI:`ASC_GAIN_LO];
    assign enable_o  = cfg_ff[`ASC_EN_BIT];
    // codes 10b and 11b both give x4
    assign gain_o    = (gain_code == 2'b00) ? `ASC_GAIN_X1 :
                       (gain_code == 2'b01) ? `ASC_GAIN_X2 : `ASC_GAIN_X4;
    // external channels 0..7 only while the code's top bit is clear
    assign pos_ext_onehot_o = pos_code[3] ? 8'h00 : (8'h01 << pos_code[2:0]);
    assign pos_temp_o  = (pos_code == `ASC_POS_TEMP);
    assign pos_short_o = (pos_code == `ASC_POS_SHORT);
    assign pos_tdac_o  = (pos_code == `ASC_POS_TDAC);
    assign pos_rail_o  = (pos_code > `ASC_POS_TDAC);
    assign rail_index_o = pos_rail_o ? (pos_code - 4'hB) : 4'h0;
    // every internal source picks its own negative input
    assign neg_auto_o  = (pos_code > `ASC_POS_LAST_EXT);
    // negative select bit is ignored while the choice is automatic
    assign neg_input_seven_o = ~neg_auto_o & cfg_ff[`ASC_NEG_BIT];

endmodule // asc_step_reg

// ### sim/asc_step_cfg_checker.sv
// concurrent checks on the ports of the step configuration bank
`timescale 1ns/10ps
module asc_step_cfg_checker (
    input wire        mclk_i,
    input wire        sys_rst_i,
    input wire [9:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0]  avs_byteenable_i,
    input wire        avs_waitrequest_o,
    input wire [1:0]  avs_response_o,
    input wire        step7_enable_o,
    input wire [2:0]  step7_gain_o,
    input wire [7:0]  step7_pos_ext_o,
    input wire        step7_pos_short_o,
    input wire        step7_pos_rail_o,
    input wire        step7_neg_input_seven_o,
    input wire        step7_neg_auto_o,
    input wire        step8_enable_o,
    input wire        step8_pos_temp_o
);
    // ------------------------------------------------------------------
    // helpers: a write on the two low byte lanes accepted at the step seven slot
    // ------------------------------------------------------------------
    wire        w7 = avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h25C
                     && avs_byteenable_i == 4'h3;
    wire [15:0] wd = avs_writedata_i[15:0];
    wire        req = avs_read_i | avs_write_i;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    en_wr_a: assert property (w7 |=> step7_enable_o == $past(wd[15]))
        else $error("step7 enable wrong");
    gain_wr_a: assert property (w7 |=> step7_gain_o == ($past(wd[14]) ? 3'h4 :
        ($past(wd[13]) ? 3'h2 : 3'h1))) else $error("step7 gain wrong");
    neg_wr_a: assert property (w7 && !wd[3] |=> step7_neg_input_seven_o == $past(wd[4]))
        else $error("step7 negative select wrong");
    ext_wr_a: assert property (w7 && !wd[3] |=> step7_pos_ext_o == 8'h01 << $past(wd[2:0]))
        else $error("step7 external input wrong");
    short_wr_a: assert property (w7 && wd[3:0] == 4'h9 |=> step7_pos_short_o)
        else $error("step7 short not selected");
    rail_wr_a: assert property (w7 && wd[3:0] > 4'hA |=> step7_pos_rail_o && step7_neg_auto_o)
        else $error("step7 rail monitor wrong");
    neg_ign_a: assert property (step7_neg_auto_o |-> !step7_neg_input_seven_o)
        else $error("negative select not ignored");
    rst_val_a: assert property ($past(sys_rst_i) |-> !step7_enable_o && step7_gain_o == 3'h1
        && step7_pos_ext_o == 8'h80) else $error("step7 reset value wrong");
    rst_eight_a: assert property ($past(sys_rst_i) |-> step8_pos_temp_o && !step8_enable_o)
        else $error("step8 reset value wrong");
    wait_one_a: assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("wait state count wrong");

    // main scenarios
    cover property (w7);
    cover property (step7_pos_rail_o);
    cover property (avs_response_o == 2'b10);
endmodule // asc_step_cfg_checker

bind asc_step_cfg asc_step_cfg_checker chk_u (.*);

// ### sim/tb.sv
// self-checking bench for the step configuration bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h seen %h", n, e, g); end end
module tb;
    reg         mclk_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg  [9:0]  avs_address_i = 10'h000;
    reg         avs_read_i = 1'b0;
    reg         avs_write_i = 1'b0;
    reg  [31:0] avs_writedata_i = 32'h0000_0000;
    reg  [3:0]  avs_byteenable_i = 4'h0;
    wire        avs_waitrequest_o;
    wire [31:0] avs_readdata_o;
    wire [1:0]  avs_response_o;
    wire        step7_enable_o, step7_pos_temp_o, step7_pos_short_o, step7_pos_tdac_o;
    wire        step7_pos_rail_o, step7_neg_input_seven_o, step7_neg_auto_o;
    wire        step8_enable_o, step8_pos_temp_o, step8_pos_short_o, step8_pos_tdac_o;
    wire        step8_pos_rail_o, step8_neg_input_seven_o, step8_neg_auto_o;
    wire [2:0]  step7_gain_o, step8_gain_o;
    wire [7:0]  step7_pos_ext_o, step8_pos_ext_o;
    wire [3:0]  step7_rail_index_o, step8_rail_index_o;
    wire [21:0] obs7 = {step7_enable_o, step7_gain_o, step7_pos_ext_o, step7_pos_temp_o,
        step7_pos_short_o, step7_pos_tdac_o, step7_pos_rail_o, step7_rail_index_o,
        step7_neg_input_seven_o, step7_neg_auto_o};
    wire [21:0] obs8 = {step8_enable_o, step8_gain_o, step8_pos_ext_o, step8_pos_temp_o,
        step8_pos_short_o, step8_pos_tdac_o, step8_pos_rail_o, step8_rail_index_o,
        step8_neg_input_seven_o, step8_neg_auto_o};
    int         error_cnt = 0;
    int         compares = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    // rows: written value, value read back, gain factor
    logic [34:0] rows [6] = '{{16'h8017, 16'h8017, 3'h1}, {16'h3FF0, 16'h2010, 3'h2},
        {16'h4009, 16'h4009, 3'h4}, {16'h6018, 16'h6018, 3'h4},
        {16'hE01A, 16'hE01A, 3'h4}, {16'h001F, 16'h001F, 3'h1}};

    asc_step_cfg dut (.*);

    // 20 MHz clock
    always #25 mclk_i = ~mclk_i;

    // expected decode of one register value
    function automatic logic [21:0] dexp(input logic [15:0] d);
        logic [3:0] c;
        c = d[3:0];
        dexp = {d[15], d[14] ? 3'h4 : (d[13] ? 3'h2 : 3'h1), c[3] ? 8'h00 : 8'h01 << c[2:0],
            c == 4'h8, c == 4'h9, c == 4'hA, c > 4'hA, c > 4'hA ? c - 4'hB : 4'h0,
            d[4] & ~c[3], c[3]};
    endfunction

    // one bus cycle; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d,
                       input logic [3:0] be);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= {16'h0000, d};
        avs_byteenable_i <= be;
        @(posedge mclk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
        // answer taken at the accepting edge; the request is released by that edge only
        rd = avs_readdata_o;
        rsp = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic rdchk(input logic s, input logic [15:0] v);
        bus(1'b0, s ? 10'h260 : 10'h25C, 16'h0000, 4'hF);
        `CHK("readback", {16'h0000, v}, rd)
        `CHK("response", 2'b00, rsp)
        `CHK("decode", dexp(v), s ? obs8 : obs7)
    endtask

    task automatic chk(input logic s, input logic [15:0] d);
        bus(1'b1, s ? 10'h260 : 10'h25C, d, 4'h3);
        `CHK("write response", 2'b00, rsp)
        rdchk(s, d & 16'hE01F);
    endtask

    task summarize;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rdchk(1'b0, 16'h0007);
        rdchk(1'b1, 16'h0008);
        $display("test reset done");
        foreach (rows[i])
        begin
            bus(1'b1, 10'h25C, rows[i][34:19], 4'h3);
            rdchk(1'b0, rows[i][18:3]);
            `CHK("gain", rows[i][2:0], step7_gain_o)
        end
        $display("test rows done");
        // every positive code on both steps, negative bit set on step seven
        for (int i = 0; i < 16; i++)
        begin
            chk(1'b0, 16'h0010 | i[15:0]);
            chk(1'b1, 16'h8000 | i[15:0]);
        end
        $display("test sweep done");
        // single byte lanes leave the other lane alone
        bus(1'b1, 10'h25C, 16'h0000, 4'h3);
        bus(1'b1, 10'h25C, 16'hFFFF, 4'h1);
        rdchk(1'b0, 16'h001F);
        bus(1'b1, 10'h25C, 16'hFFFF, 4'h2);
        rdchk(1'b0, 16'hE01F);
        $display("test lanes done");
        // misaligned write is dropped, unmapped read is refused
        bus(1'b1, 10'h25E, 16'h0000, 4'h3);
        `CHK("misaligned response", 2'b10, rsp)
        rdchk(1'b0, 16'hE01F);
        bus(1'b0, 10'h264, 16'h0000, 4'hF);
        `CHK("unmapped response", 2'b10, rsp)
        `CHK("unmapped data", 32'h0000_0000, rd)
        $display("test unmapped done");
        // second reset in mid-run restores both registers
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rdchk(1'b0, 16'h0007);
        rdchk(1'b1, 16'h0008);
        $display("test second reset done");
        summarize();
    end

    // watchdog: far beyond the few hundred cycles the tests need
    initial
    begin
        #(4000 * 50);
        error_cnt++;
        summarize();
    end
endmodule // tb
